/* File: logic/cmc_pkg.sv */
// Package: constants and types for the CAN mode and control registers
package cmc_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] OFS_MODE_CONTROL = 8'h00;
  localparam logic [7:0] OFS_FILTER_BIT_COUNT = 8'h04;
  localparam logic [7:0] OFS_INTERRUPT_CODE = 8'h08;
  localparam logic [7:0] OFS_FIFO_AREA = 8'h0c;
  localparam logic [7:0] OFS_CONFIG_TWO = 8'h10;

  // Mode control field positions
  localparam int IDLE_STOP_BIT = 13;
  localparam int ABORT_ALL_BIT = 12;
  localparam int CLK_SEL_BIT = 11;
  localparam int REQ_MODE_LSB = 8;
  localparam int CUR_MODE_LSB = 5;
  localparam int CAPTURE_BIT = 3;
  localparam int WINDOW_BIT = 0;
  // Config register two, fifo area, status field positions
  localparam int WAKE_LP_BIT = 14;
  localparam int BUF_COUNT_LSB = 13;
  localparam int FIFO_START_LSB = 0;
  localparam int FILTER_HIT_LSB = 8;
  localparam int INT_CODE_LSB = 0;

  // Mode encoding, shared by request and current fields
  typedef enum logic [2:0] {
    CMC_NORMAL = 3'h0,
    CMC_DISABLE = 3'h1,
    CMC_LOOPBACK = 3'h2,
    CMC_LISTEN_ONLY = 3'h3,
    CMC_CONFIG = 3'h4,
    CMC_RSVD_A = 3'h5,
    CMC_RSVD_B = 3'h6,
    CMC_LISTEN_ALL = 3'h7
  } cmc_mode_t;

  // Reset values, last valid status codes and the reserved buffer count code
  localparam cmc_mode_t MODE_RESET = CMC_CONFIG;
  localparam logic [6:0] INT_CODE_RESET = 7'h40;
  localparam logic [6:0] INT_CODE_LAST = 7'h44;
  localparam logic [6:0] INT_CODE_BUF_LAST = 7'h0f;
  localparam logic [4:0] FILTER_HIT_LAST = 5'h0f;
  localparam logic [4:0] DATA_BIT_LAST = 5'h11;
  localparam logic [2:0] BUF_COUNT_RSVD = 3'h7;

  // Timing
  localparam logic [3:0] IDLE_BITS = 4'hb;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int WAKE_FILTER_NS = 200;
  localparam int WAKE_FILTER_CYC =
    (WAKE_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Controls handed to the protocol engine
  typedef struct packed {
    logic rx_en;
    logic tx_en;
    logic tx_permit;
    logic ack_err_en;
    logic err_cnt_en;
    logic err_cnt_clr;
    logic ignore_err;
    logic loopback;
    logic tx_pin_own;
    logic rx_pin_own;
    logic cfg_unlock;
    logic clk_sel;
    logic win_sel;
  } cmc_eng_ctrl_t;

endpackage

/* File: logic/cmc_mode_ctrl.sv */
// Mode sequencing, control and status registers of a CAN controller
// Notes on behaviour
// (RULE1) Disable mode: no transmit or receive; wake flag may still rise.
// (RULE2) Disable request while active waits for 11 recessive bits first.
// (RULE3) Current mode reads disable only after disable is really entered.
// (RULE4) Disable mode releases transmit and receive pins to general I/O.
// (RULE5) Wake low-pass bit filters receive input during sleep or disable.
// (RULE6) New transmit waits 11 recessive bits; disable then aborts it.
// (RULE7) Code 000 is normal mode: pins owned, frames sent and received.
// (RULE8) Listen-only 011: passive, no error flags or acks, counters off.
// (RULE9) Listen-all 111: errors ignored, partial frame kept on error.
// (RULE10) Loopback 010: internal transmit feeds internal receive, pins free.
// (RULE11) Code 100 is configuration; 101, 110 reserved; same encodings.
// (RULE12) Idle-stop bit halts the controller while the device idles.
// (RULE13) Abort-all aborts every buffer; hardware clears it when done.
// (RULE14) Clock select: 1 instruction-cycle clock, 0 oscillator clock.
// (RULE15) Capture enable sends a capture event on each reception.
// (RULE16) Window bit: 1 filter registers, 0 buffer registers.
// (RULE17) Five-bit data bit count; codes above 10001 are invalid.
// (RULE18) Filter hit index holds matching filter 0 to 15; rest reserved.
// (RULE19) Interrupt code: buffers 0-15, 40-44 events, others reserved.
// (RULE20) Buffer count codes 0-6 give 4 to 32 buffers; 7 reserved.
// (RULE21) Fifo start names first receive fifo buffer, 0 to 31.
// (RULE22) Mode changes only when acceptable, normally after bus idle.
// (RULE23) Config entry stops traffic, clears error counters, unlocks regs.
// (RULE24) Reserved request codes are ignored; mode stays as it was.
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module cmc_mode_ctrl (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic bus_receive_pin_i,
  output logic bus_transmit_pin_o,
  output logic bus_transmit_pin_oe_o,
  input wire logic bit_tick_i,
  input wire logic engine_tx_i,
  input wire logic tx_busy_i,
  input wire logic [7:0] tx_pending_i,
  input wire logic rx_done_i,
  input wire logic rx_error_i,
  input wire logic [4:0] data_bit_count_i,
  input wire logic hit_valid_i,
  input wire logic [4:0] filter_hit_index_i,
  input wire logic [6:0] interrupt_source_code_i,
  input wire logic cpu_idle_i,
  input wire logic cpu_sleep_i,
  output logic engine_rx_o,
  output var cmc_pkg::cmc_eng_ctrl_t eng_ctrl_o,
  output logic [7:0] tx_abort_o,
  output logic partial_store_o,
  output logic wake_activity_o,
  output logic rx_capture_event_o,
  output logic [5:0] buffer_count_o,
  output logic [4:0] fifo_start_buffer_o,
  output logic [4:0] filter_data_bit_count_o,
  output logic halted_o
);

  function automatic logic mode_active(input cmc_pkg::cmc_mode_t m);
    mode_active = (m != cmc_pkg::CMC_DISABLE) && (m != cmc_pkg::CMC_CONFIG);
  endfunction

  function automatic logic mode_reserved(input logic [2:0] m);
    mode_reserved = (m == cmc_pkg::CMC_RSVD_A) || (m == cmc_pkg::CMC_RSVD_B);
  endfunction

  function automatic logic mode_can_tx(input cmc_pkg::cmc_mode_t m);
    mode_can_tx = (m == cmc_pkg::CMC_NORMAL) || (m == cmc_pkg::CMC_LOOPBACK);
  endfunction

  // Saturating count of consecutive recessive bits
  function automatic logic [3:0] idle_next(input logic [3:0] c,
                                           input logic tick,
                                           input logic rx);
    if (!tick) begin
      idle_next = c;
    end else if (!rx) begin
      idle_next = 4'h0;
    end else if (c < cmc_pkg::IDLE_BITS) begin
      idle_next = c + 4'h1;
    end else begin
      idle_next = c;
    end
  endfunction

  function automatic logic [5:0] buf_count(input logic [2:0] code);
    case (code)
      3'h0: buf_count = 6'h04;
      3'h1: buf_count = 6'h06;
      3'h2: buf_count = 6'h08;
      3'h3: buf_count = 6'h0c;
      3'h4: buf_count = 6'h10;
      3'h5: buf_count = 6'h18;
      default: buf_count = 6'h20;
    endcase
  endfunction

  // Receive pin synchroniser
  logic rx_meta_reg;
  logic rx_sync_reg;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end else begin
      rx_meta_reg <= bus_receive_pin_i;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  // Register state
  cmc_pkg::cmc_mode_t req_reg;
  cmc_pkg::cmc_mode_t cur_reg;
  logic idle_stop_reg;
  logic abort_all_reg;
  logic clk_sel_reg;
  logic capture_en_reg;
  logic win_reg;
  logic wake_lp_reg;
  logic [2:0] buf_sel_reg;
  logic [4:0] fifo_start_reg;
  logic [4:0] dbit_reg;
  logic [4:0] hit_reg;
  logic [6:0] interrupt_source_code_reg;
  logic [3:0] idle_cnt_reg;
  logic [3:0] entry_cnt_reg;
  logic [7:0] wake_cnt_reg;
  logic wake_seen_reg;

  // APB decode
  wire logic access = psel_i & penable_i & ~pready_o;
  // Writes land on the edge that samples pready high, ending the transfer
  wire logic wr = psel_i & penable_i & pready_o & pwrite_i;
  wire logic hit_mode = paddr_i == cmc_pkg::OFS_MODE_CONTROL;
  wire logic hit_fbc = paddr_i == cmc_pkg::OFS_FILTER_BIT_COUNT;
  wire logic hit_ic = paddr_i == cmc_pkg::OFS_INTERRUPT_CODE;
  wire logic hit_fifo = paddr_i == cmc_pkg::OFS_FIFO_AREA;
  wire logic hit_cfg2 = paddr_i == cmc_pkg::OFS_CONFIG_TWO;
  wire logic mapped = hit_mode | hit_fbc | hit_ic | hit_fifo | hit_cfg2;
  wire logic in_config = cur_reg == cmc_pkg::CMC_CONFIG;
  // Locked registers ignore writes outside configuration mode
  wire logic wr_mode = wr & hit_mode;
  wire logic wr_fifo = wr & hit_fifo & in_config; // RULE23
  wire logic wr_cfg2 = wr & hit_cfg2 & in_config; // RULE23
  wire logic [2:0] wr_req = pwdata_i[cmc_pkg::REQ_MODE_LSB +: 3];
  wire logic [2:0] wr_buf = pwdata_i[cmc_pkg::BUF_COUNT_LSB +: 3];

  wire logic [15:0] mode_word = {2'h0, idle_stop_reg, abort_all_reg,
    clk_sel_reg, req_reg, cur_reg, 1'b0, capture_en_reg, 2'h0, win_reg};
  wire logic [15:0] fbc_word = {11'h0, dbit_reg};
  wire logic [15:0] ic_word = {3'h0, hit_reg, 1'b0, interrupt_source_code_reg};
  wire logic [15:0] fifo_word = {buf_sel_reg, 8'h0, fifo_start_reg};
  wire logic [15:0] cfg2_word = {1'b0, wake_lp_reg, 14'h0};
  wire logic [15:0] rd_word = hit_mode ? mode_word :
                              hit_fbc ? fbc_word :
                              hit_ic ? ic_word :
                              hit_fifo ? fifo_word :
                              hit_cfg2 ? cfg2_word : 16'h0;

  // Access phase takes two cycles: pready rises on the second
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0;
    end else begin
      pready_o <= access;
      pslverr_o <= access & ~mapped;
      prdata_o <= (access & ~pwrite_i) ? {16'h0, rd_word} : 32'h0;
    end
  end

  // Bus idle and mode sequencing
  wire logic rx_line = (cur_reg == cmc_pkg::CMC_LOOPBACK) ?
                       engine_tx_i : rx_sync_reg; // RULE10
  wire logic bus_idle = idle_cnt_reg == cmc_pkg::IDLE_BITS;
  wire logic change_pending = req_reg != cur_reg;
  // Leaving an active mode needs bus idle and no frame in flight
  wire logic change_ok = change_pending &
    (~mode_active(cur_reg) | (bus_idle & ~tx_busy_i)); // RULE2 RULE22
  wire logic tx_hold = entry_cnt_reg != cmc_pkg::IDLE_BITS;
  wire logic early_abort = mode_can_tx(cur_reg) & tx_hold &
    (req_reg == cmc_pkg::CMC_DISABLE); // RULE6
  wire logic halted = idle_stop_reg & cpu_idle_i; // RULE12

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cur_reg <= cmc_pkg::MODE_RESET;
      idle_cnt_reg <= 4'h0;
      entry_cnt_reg <= 4'h0;
    end else begin
      idle_cnt_reg <= idle_next(idle_cnt_reg, bit_tick_i, rx_line);
      if (change_ok) begin
        cur_reg <= req_reg; // RULE3 RULE11
        entry_cnt_reg <= 4'h0; // RULE6
      end else begin
        entry_cnt_reg <= idle_next(entry_cnt_reg, bit_tick_i, rx_line);
      end
    end
  end

  // Software-written control fields
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      req_reg <= cmc_pkg::MODE_RESET;
      idle_stop_reg <= 1'b0;
      clk_sel_reg <= 1'b0;
      capture_en_reg <= 1'b0;
      win_reg <= 1'b0;
    end else if (wr_mode) begin
      if (!mode_reserved(wr_req)) begin
        req_reg <= cmc_pkg::cmc_mode_t'(wr_req); // RULE24
      end
      idle_stop_reg <= pwdata_i[cmc_pkg::IDLE_STOP_BIT]; // RULE12
      clk_sel_reg <= pwdata_i[cmc_pkg::CLK_SEL_BIT]; // RULE14
      capture_en_reg <= pwdata_i[cmc_pkg::CAPTURE_BIT]; // RULE15
      win_reg <= pwdata_i[cmc_pkg::WINDOW_BIT]; // RULE16
    end
  end

  // Abort-all: software sets, hardware clears; a set in the same cycle wins
  wire logic abort_set = wr_mode & pwdata_i[cmc_pkg::ABORT_ALL_BIT];
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      abort_all_reg <= 1'b0;
    end else if (abort_set) begin
      abort_all_reg <= 1'b1; // RULE13
    end else if (tx_pending_i == 8'h0) begin
      abort_all_reg <= 1'b0; // RULE13
    end
  end

  // Locked configuration fields
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wake_lp_reg <= 1'b0;
      buf_sel_reg <= 3'h0;
      fifo_start_reg <= 5'h0;
    end else begin
      if (wr_cfg2) begin
        wake_lp_reg <= pwdata_i[cmc_pkg::WAKE_LP_BIT]; // RULE5
      end
      if (wr_fifo) begin
        if (wr_buf != cmc_pkg::BUF_COUNT_RSVD) begin
          buf_sel_reg <= wr_buf; // RULE20
        end
        fifo_start_reg <= pwdata_i[cmc_pkg::FIFO_START_LSB +: 5]; // RULE21
      end
    end
  end

  // Status capture; invalid or reserved codes keep the last good value
  wire logic dbit_ok = data_bit_count_i <= cmc_pkg::DATA_BIT_LAST;
  wire logic hit_ok = hit_valid_i &
    (filter_hit_index_i <= cmc_pkg::FILTER_HIT_LAST);
  wire logic interrupt_source_code_ok =
    (interrupt_source_code_i <= cmc_pkg::INT_CODE_BUF_LAST) |
    ((interrupt_source_code_i >= cmc_pkg::INT_CODE_RESET) &
     (interrupt_source_code_i <= cmc_pkg::INT_CODE_LAST));
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dbit_reg <= 5'h0;
      hit_reg <= 5'h0;
      interrupt_source_code_reg <= cmc_pkg::INT_CODE_RESET;
    end else begin
      if (dbit_ok) begin
        dbit_reg <= data_bit_count_i; // RULE17
      end
      if (hit_ok) begin
        hit_reg <= filter_hit_index_i; // RULE18
      end
      if (interrupt_source_code_ok) begin
        interrupt_source_code_reg <= interrupt_source_code_i; // RULE19
      end
    end
  end

  // Wake detection; the filter rejects short glitches on a quiet bus
  wire logic wake_window = (cur_reg == cmc_pkg::CMC_DISABLE) | cpu_sleep_i;
  wire logic filter_on = wake_lp_reg & wake_window; // RULE5
  wire logic [7:0] wake_need =
    filter_on ? 8'(cmc_pkg::WAKE_FILTER_CYC) : 8'h1;
  wire logic wake_hit = wake_cnt_reg >= wake_need;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wake_cnt_reg <= 8'h0;
      wake_seen_reg <= 1'b0;
    end else if (rx_sync_reg) begin
      wake_cnt_reg <= 8'h0;
      wake_seen_reg <= 1'b0;
    end else begin
      if (!wake_hit) begin
        wake_cnt_reg <= wake_cnt_reg + 8'h1;
      end
      wake_seen_reg <= wake_hit;
    end
  end

  // Engine controls by mode
  cmc_pkg::cmc_eng_ctrl_t ctrl_next;
  always_comb begin
    ctrl_next = '0;
    ctrl_next.clk_sel = clk_sel_reg; // RULE14
    ctrl_next.win_sel = win_reg; // RULE16
    case (cur_reg)
      cmc_pkg::CMC_NORMAL: begin
        ctrl_next.rx_en = 1'b1; // RULE7
        ctrl_next.tx_en = 1'b1;
        ctrl_next.ack_err_en = 1'b1;
        ctrl_next.err_cnt_en = 1'b1;
        ctrl_next.tx_pin_own = 1'b1;
        ctrl_next.rx_pin_own = 1'b1;
      end
      cmc_pkg::CMC_LISTEN_ONLY: begin
        ctrl_next.rx_en = 1'b1; // RULE8
        ctrl_next.rx_pin_own = 1'b1;
      end
      cmc_pkg::CMC_LISTEN_ALL: begin
        ctrl_next.rx_en = 1'b1; // RULE9
        ctrl_next.ignore_err = 1'b1;
        ctrl_next.rx_pin_own = 1'b1;
      end
      cmc_pkg::CMC_LOOPBACK: begin
        ctrl_next.rx_en = 1'b1; // RULE10
        ctrl_next.tx_en = 1'b1;
        ctrl_next.ack_err_en = 1'b1;
        ctrl_next.err_cnt_en = 1'b1;
        ctrl_next.loopback = 1'b1;
      end
      cmc_pkg::CMC_CONFIG: begin
        ctrl_next.err_cnt_clr = 1'b1; // RULE23
        ctrl_next.cfg_unlock = 1'b1; // RULE23
      end
      default: begin
        ctrl_next.rx_en = 1'b0; // RULE1 RULE4
      end
    endcase
    if (halted) begin
      ctrl_next.rx_en = 1'b0; // RULE12
      ctrl_next.tx_en = 1'b0;
    end
    ctrl_next.tx_permit = ctrl_next.tx_en & ~tx_hold; // RULE6
  end

  // Registered outputs
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      eng_ctrl_o <= '0;
      engine_rx_o <= 1'b1;
      bus_transmit_pin_o <= 1'b1;
      bus_transmit_pin_oe_o <= 1'b0;
      tx_abort_o <= 8'h0;
      partial_store_o <= 1'b0;
      wake_activity_o <= 1'b0;
      rx_capture_event_o <= 1'b0;
      buffer_count_o <= 6'h04;
      fifo_start_buffer_o <= 5'h0;
      filter_data_bit_count_o <= 5'h0;
      halted_o <= 1'b0;
    end else begin
      eng_ctrl_o <= ctrl_next;
      engine_rx_o <= ctrl_next.rx_en ? rx_line : 1'b1; // RULE1 RULE10
      bus_transmit_pin_o <= engine_tx_i;
      bus_transmit_pin_oe_o <= ctrl_next.tx_pin_own; // RULE4 RULE8
      tx_abort_o <= (abort_all_reg | early_abort) ?
                    tx_pending_i : 8'h0; // RULE6 RULE13
      partial_store_o <= rx_error_i & ctrl_next.ignore_err; // RULE9
      wake_activity_o <= wake_hit & ~wake_seen_reg & wake_window;
      rx_capture_event_o <= rx_done_i & capture_en_reg &
                            ctrl_next.rx_en; // RULE15
      buffer_count_o <= buf_count(buf_sel_reg); // RULE20
      fifo_start_buffer_o <= fifo_start_reg; // RULE21
      filter_data_bit_count_o <= dbit_reg; // RULE17
      halted_o <= halted; // RULE12
    end
  end

  // Checks
  AST_DISABLE_QUIET: assert property ( // RULE1
    @(posedge clk_i) disable iff (sys_rst_i)
    cur_reg == cmc_pkg::CMC_DISABLE |=> !eng_ctrl_o.rx_en && !eng_ctrl_o.tx_en
      && !bus_transmit_pin_oe_o)
    else $error("traffic enabled in disable mode");

  AST_WAIT_IDLE: assert property ( // RULE22
    @(posedge clk_i) disable iff (sys_rst_i)
    change_pending && mode_active(cur_reg) && bus_idle && !tx_busy_i
      |=> cur_reg == $past(req_reg))
    else $error("mode change not taken on idle bus");

  AST_LEAVE_ACTIVE: assert property ( // RULE2
    @(posedge clk_i) disable iff (sys_rst_i)
    mode_active(cur_reg) && !bus_idle |=> cur_reg == $past(cur_reg))
    else $error("active mode left before bus idle");

  AST_CUR_FOLLOWS_REQ: assert property ( // RULE3
    @(posedge clk_i) disable iff (sys_rst_i)
    !mode_active(cur_reg) && change_pending |=> cur_reg == $past(req_reg))
    else $error("current mode did not take request");

  AST_NO_RESERVED: assert property ( // RULE24
    @(posedge clk_i) disable iff (sys_rst_i)
    !mode_reserved(cur_reg) && !mode_reserved(req_reg))
    else $error("reserved mode code seen");

  AST_LOOP_PINS: assert property ( // RULE10
    @(posedge clk_i) disable iff (sys_rst_i)
    cur_reg == cmc_pkg::CMC_LOOPBACK ##1 cur_reg == cmc_pkg::CMC_LOOPBACK
      |-> eng_ctrl_o.loopback && !bus_transmit_pin_oe_o)
    else $error("loopback drives transmit pin");

  AST_LISTEN_PASSIVE: assert property ( // RULE8
    @(posedge clk_i) disable iff (sys_rst_i)
    cur_reg == cmc_pkg::CMC_LISTEN_ONLY |=> !eng_ctrl_o.ack_err_en &&
      !eng_ctrl_o.err_cnt_en && !bus_transmit_pin_oe_o)
    else $error("listen-only not passive");

  AST_ABORT_CLEAR: assert property ( // RULE13
    @(posedge clk_i) disable iff (sys_rst_i)
    abort_all_reg && tx_pending_i == 8'h0 && !abort_set |=> !abort_all_reg)
    else $error("abort-all not cleared");

  AST_TX_HOLD: assert property ( // RULE6
    @(posedge clk_i) disable iff (sys_rst_i)
    $changed(cur_reg) |=> (!eng_ctrl_o.tx_permit) [*2])
    else $error("transmit permitted before idle bits");

  AST_CAPTURE: assert property ( // RULE15
    @(posedge clk_i) disable iff (sys_rst_i)
    rx_capture_event_o |-> $past(capture_en_reg) && $past(rx_done_i))
    else $error("capture event without enable");

  AST_BUF_COUNT: assert property ( // RULE20
    @(posedge clk_i) disable iff (sys_rst_i)
    buf_sel_reg != cmc_pkg::BUF_COUNT_RSVD)
    else $error("reserved buffer count stored");

  COV_TO_NORMAL: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    cur_reg == cmc_pkg::CMC_CONFIG ##1 cur_reg == cmc_pkg::CMC_NORMAL);
  COV_TO_DISABLE: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    cur_reg == cmc_pkg::CMC_NORMAL ##1 cur_reg == cmc_pkg::CMC_DISABLE);
  COV_EARLY_ABORT: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    early_abort && tx_pending_i != 8'h0);
  COV_WAKE: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    wake_activity_o && filter_on);

endmodule

`default_nettype wire

/* File: testbench/cmc_can_side.sv */
// Far-side model: CAN bus level and bit timing
`timescale 1ns/1ps
`default_nettype none
module cmc_can_side (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic dominant_i,
  output logic bus_level_o,
  output logic bit_tick_o
);
  logic [1:0] div_reg;
  // Short bit time keeps idle waits near 44 clocks
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_reg <= 2'h0;
    end else begin
      div_reg <= div_reg + 2'h1;
    end
  end
  assign bit_tick_o = (div_reg == 2'h3);
  // Bus floats recessive unless some node drives dominant
  assign bus_level_o = ~dominant_i;
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// Testbench for the CAN mode and control registers
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [7:0] MC = cmc_pkg::OFS_MODE_CONTROL;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err_seen, rx_pin, tick;
  logic dominant = 1'b0;
  logic eng_tx = 1'b1;
  logic [7:0] pend = 8'h00;
  logic rx_done = 1'b0;
  logic rx_err = 1'b0;
  logic [4:0] dbc = 5'h00;
  logic hit_v = 1'b0;
  logic [4:0] hit = 5'h00;
  logic [6:0] interrupt_source_code = 7'h40;
  logic cpu_idle = 1'b0;
  logic cpu_sleep = 1'b0;
  logic abort_arm = 1'b0;
  logic [7:0] abort_seen = 8'h00;
  int wakes = 0;
  logic eng_rx, tx_pin, tx_oe, pstore, wake, cap, halted;
  cmc_pkg::cmc_eng_ctrl_t ctl;
  logic [7:0] abort;
  logic [5:0] bufs;
  logic [4:0] fstart, fdbc;
  int failures = 0;
  int samples_checked = 0;

  cmc_can_side bus_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .dominant_i(dominant), .bus_level_o(rx_pin), .bit_tick_o(tick));

  cmc_mode_ctrl dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr),
    .bus_receive_pin_i(rx_pin), .bus_transmit_pin_o(tx_pin),
    .bus_transmit_pin_oe_o(tx_oe), .bit_tick_i(tick),
    .engine_tx_i(eng_tx), .tx_busy_i(1'b0), .tx_pending_i(pend),
    .rx_done_i(rx_done), .rx_error_i(rx_err),
    .data_bit_count_i(dbc), .hit_valid_i(hit_v),
    .filter_hit_index_i(hit), .interrupt_source_code_i(interrupt_source_code),
    .cpu_idle_i(cpu_idle), .cpu_sleep_i(cpu_sleep), .engine_rx_o(eng_rx),
    .eng_ctrl_o(ctl), .tx_abort_o(abort), .partial_store_o(pstore),
    .wake_activity_o(wake), .rx_capture_event_o(cap),
    .buffer_count_o(bufs), .fifo_start_buffer_o(fstart),
    .filter_data_bit_count_o(fdbc), .halted_o(halted));

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  // One-cycle pulses are caught here so checks may come later
  always @(posedge clk_i) begin
    if (wake === 1'b1) begin
      wakes <= wakes + 1;
    end
    if (abort_arm) begin
      abort_seen <= abort_seen | abort;
    end
  end

  task automatic final_report();
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Entered just after a rising edge; holds request until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge clk_i);
      n++;
    end
    if (pready !== 1'b1) begin
      failures++;
      final_report();
    end
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Write lands at the pready edge; outputs follow one edge later
    repeat (2) @(posedge clk_i);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Mode change needs bus idle, so poll with a bound
  task automatic wait_mode(input logic [2:0] m);
    int k;
    k = 0;
    apb(1'b0, MC, 32'h0);
    while (rd[7:5] !== m && k < 40) begin
      apb(1'b0, MC, 32'h0);
      k++;
    end
    chk({29'h0, rd[7:5]}, {29'h0, m});
    if (rd[7:5] !== m) begin
      final_report();
    end
  endtask

  initial begin
    repeat (30000) @(posedge clk_i);
    failures++;
    final_report();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    rchk(MC, 32'h0480);
    rchk(cmc_pkg::OFS_INTERRUPT_CODE, 32'h0040);
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, err_seen}, 32'h1);
    apb(1'b1, cmc_pkg::OFS_FIFO_AREA, 32'hc01f);
    chk({26'h0, bufs}, 32'h20);
    chk({27'h0, fstart}, 32'h1f);
    apb(1'b1, cmc_pkg::OFS_FIFO_AREA, 32'he000);
    chk({26'h0, bufs}, 32'h20);
    apb(1'b1, cmc_pkg::OFS_CONFIG_TWO, 32'h4000);
    rchk(cmc_pkg::OFS_CONFIG_TWO, 32'h4000);
    dbc <= 5'h11;
    hit <= 5'h0f;
    hit_v <= 1'b1;
    interrupt_source_code <= 7'h44;
    @(posedge clk_i);
    hit_v <= 1'b0;
    dbc <= 5'h12;
    interrupt_source_code <= 7'h45;
    rchk(cmc_pkg::OFS_FILTER_BIT_COUNT, 32'h0011);
    chk({27'h0, fdbc}, 32'h11);
    rchk(cmc_pkg::OFS_INTERRUPT_CODE, 32'h0f44);
    apb(1'b1, MC, 32'h0000);
    wait_mode(3'h0);
    chk({31'h0, ctl.tx_permit}, 32'h0);
    repeat (60) @(posedge clk_i);
    chk({30'h0, tx_oe, ctl.tx_permit}, 32'h3);
    // Dominant bus must hold off the disable request
    cpu_sleep <= 1'b1;
    dominant <= 1'b1;
    apb(1'b1, MC, 32'h0100);
    repeat (60) @(posedge clk_i);
    rchk(MC, 32'h0100);
    chk(wakes, 32'h1);
    cpu_sleep <= 1'b0;
    dominant <= 1'b0;
    wait_mode(3'h1);
    chk({30'h0, tx_oe, ctl.tx_en}, 32'h0);
    chk({31'h0, ctl.rx_en}, 32'h0);
    // Short glitch is filtered out, long dominant still wakes
    dominant <= 1'b1;
    repeat (8) @(posedge clk_i);
    dominant <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(wakes, 32'h1);
    dominant <= 1'b1;
    repeat (40) @(posedge clk_i);
    dominant <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(wakes, 32'h2);
    apb(1'b1, MC, 32'h0500);
    rchk(MC, 32'h0120);
    apb(1'b1, MC, 32'h0208);
    wait_mode(3'h2);
    eng_tx <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({29'h0, eng_rx, tx_oe, tx_pin}, 32'h0);
    eng_tx <= 1'b1;
    rx_done <= 1'b1;
    @(posedge clk_i);
    rx_done <= 1'b0;
    @(negedge clk_i);
    chk({31'h0, cap}, 32'h1);
    @(posedge clk_i);
    pend <= 8'h5a;
    apb(1'b1, MC, 32'h1208);
    chk({24'h0, abort}, 32'h5a);
    rchk(MC, 32'h1248);
    pend <= 8'h00;
    repeat (3) @(posedge clk_i);
    rchk(MC, 32'h0248);
    apb(1'b1, MC, 32'h0300);
    wait_mode(3'h3);
    chk({29'h0, ctl.ack_err_en, ctl.err_cnt_en, tx_oe}, 32'h0);
    apb(1'b1, MC, 32'h0700);
    wait_mode(3'h7);
    chk({31'h0, ctl.ignore_err}, 32'h1);
    rx_err <= 1'b1;
    @(posedge clk_i);
    rx_err <= 1'b0;
    @(negedge clk_i);
    chk({31'h0, pstore}, 32'h1);
    @(posedge clk_i);
    apb(1'b1, MC, 32'h0400);
    wait_mode(3'h4);
    chk({29'h0, ctl.cfg_unlock, ctl.tx_en, ctl.rx_en}, 32'h4);
    cpu_idle <= 1'b1;
    apb(1'b1, MC, 32'h2c01);
    repeat (2) @(posedge clk_i);
    chk({29'h0, halted, ctl.clk_sel, ctl.win_sel}, 32'h7);
    apb(1'b1, MC, 32'h0400);
    repeat (2) @(posedge clk_i);
    chk({29'h0, halted, ctl.clk_sel, ctl.win_sel}, 32'h0);
    // Disable right after entering normal aborts the waiting send
    apb(1'b1, MC, 32'h0000);
    pend <= 8'h81;
    abort_arm <= 1'b1;
    apb(1'b1, MC, 32'h0100);
    repeat (2) @(posedge clk_i);
    chk({24'h0, abort_seen}, 32'h81);
    final_report();
  end
endmodule
`default_nettype wire
